// >>> pkg/sacb_cfg.svh
`ifndef SACB_CFG_SVH
`define SACB_CFG_SVH
// register indices; byte address is four times the index
`define SACB_IDX_CFG1 8'hc2
`define SACB_IDX_CFG2 8'hc3
`define SACB_IDX_OCALU 8'hc4
`define SACB_RST_CFG1 16'h0400
`define SACB_RST_CFG2 16'h8010
`define SACB_RST_OCALU 16'h0000
`define SACB_MASK_CFG1 16'h0f0f
`define SACB_MASK_CFG2 16'h8f3f
`define SACB_MASK_OCALU 16'hffff
// field positions
`define SACB_B_CONV_STYLE 11
`define SACB_B_OSR_LO 8
`define SACB_B_GC_EN 3
`define SACB_B_GC_DLY_LO 0
`define SACB_B_CONV_EN 15
`define SACB_B_GAIN_LO 10
`define SACB_B_MUX_LO 8
`define SACB_B_SRC_ROUTE 5
`define SACB_B_SNK_ROUTE 4
`define SACB_B_SRC_LVL_LO 2
`define SACB_B_SNK_LVL_LO 0
// timing: base oversampling ratio and base chop delay in modulator periods
`define SACB_OSR_BASE 14'h0040
`define SACB_GC_DLY_BASE 9'h002
`define SACB_RD_LATENCY 1
`endif

// >>> pkg/sacb_pkg.sv
package sacb_pkg;
  typedef enum logic [1:0] {
    sacb_mux_direct,
    sacb_mux_swapped,
    sacb_mux_short_gnd,
    sacb_mux_test_dac
  } sacb_mux_t;
  typedef enum logic [1:0] {
    sacb_ow_off,
    sacb_ow_4ua,
    sacb_ow_40ua,
    sacb_ow_240ua
  } sacb_ow_level_t;
  typedef enum logic {
    sacb_conv_continuous,
    sacb_conv_single
  } sacb_conv_style_t;
endpackage : sacb_pkg

// >>> rtl/sacb_ratio_decode.sv
`timescale 1ns/1ps
`include "sacb_cfg.svh"
module sacb_ratio_decode (
  input wire logic [2:0] i_osr_code,
  input wire logic [2:0] i_delay_code,
  output logic [13:0] o_osr_ratio,
  output logic [8:0] o_chop_delay
);
  // ratio 64 shifted by code, delay 2 shifted by code
  assign o_osr_ratio = 14'(`SACB_OSR_BASE << i_osr_code); // [RQ2]
  assign o_chop_delay = 9'(`SACB_GC_DLY_BASE << i_delay_code); // [RQ4]
endmodule : sacb_ratio_decode

// >>> rtl/sacb_front_route.sv
`timescale 1ns/1ps
module sacb_front_route (
  input wire logic [1:0] i_gain_code,
  input wire logic [1:0] i_mux_code,
  input wire logic i_src_route,
  input wire logic i_snk_route,
  output logic [3:0] o_analog_gain,
  output logic [2:0] o_digital_shift,
  output logic [3:0] o_mux_onehot,
  output logic o_src_to_pos,
  output logic o_src_to_neg,
  output logic o_snk_to_pos,
  output logic o_snk_to_neg
);
  // gains 16 and 32 keep the analog stage at 8 to limit front-end noise
  always_comb begin
    case (i_gain_code)
      2'h0: begin o_analog_gain = 4'h4; o_digital_shift = 3'h0; end
      2'h1: begin o_analog_gain = 4'h8; o_digital_shift = 3'h0; end
      2'h2: begin o_analog_gain = 4'h8; o_digital_shift = 3'h1; end
      default: begin o_analog_gain = 4'h8; o_digital_shift = 3'h2; end
    endcase // [RQ7]
  end
  // bit0 direct, bit1 swapped, bit2 short to ground, bit3 test dac
  assign o_mux_onehot = 4'(4'h1 << i_mux_code); // [RQ8]
  assign o_src_to_pos = ~i_src_route; // [RQ9]
  assign o_src_to_neg = i_src_route; // [RQ9]
  assign o_snk_to_pos = ~i_snk_route; // [RQ10]
  assign o_snk_to_neg = i_snk_route; // [RQ10]
endmodule : sacb_front_route

// >>> rtl/sacb_top.sv
// Functional notes
// RQ1 - conversion style bit: 0 continuous, 1 single-shot; resets 0
// RQ2 - oversampling code 0..7 selects ratio 64..8192; reset code 4
// RQ3 - global chop enable bit turns chop on; resets off
// RQ4 - chop settle delay 2 to 256 modulator periods, doubling per code
// RQ5 - disable, standby or power-down forces data 000000h and counter 00b
// RQ6 - converter enable at bit 15 of config two resets to enabled
// RQ7 - gain codes give 4,8,16,32; 16 and 32 use analog 8 plus digital
// RQ8 - mux: direct, swapped, short to ground, test dac
// RQ9 - source route: 0 positive pin, 1 negative pin; resets 0
// RQ10 - sink route: 0 positive pin, 1 negative pin; resets 1
// RQ11 - source level off, 4, 40, 240 uA; resets off
// RQ12 - sink level off, 4, 40, 240 uA; resets off
// RQ13 - upper offset register holds correction bits 23:8; resets zero
// RQ14 - 24-bit offset correction is two's complement
// RQ15 - reserved bits ignore writes and read zero
`timescale 1ns/1ps
`include "sacb_cfg.svh"
module sacb_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [1:0] o_avs_response,
  input wire logic i_standby,
  input wire logic i_power_down,
  input wire logic [7:0] i_offset_lower,
  input wire logic i_conv_done,
  input wire logic [23:0] i_conv_data,
  output logic [23:0] o_conv_data,
  output logic [1:0] o_conversion_counter,
  output logic o_converter_run,
  output sacb_pkg::sacb_conv_style_t o_conversion_style,
  output logic [13:0] o_osr_ratio,
  output logic o_global_chop_enable,
  output logic [8:0] o_chop_delay,
  output logic [3:0] o_analog_gain,
  output logic [2:0] o_digital_shift,
  output logic [3:0] o_mux_onehot,
  output logic o_src_to_pos,
  output logic o_src_to_neg,
  output logic o_snk_to_pos,
  output logic o_snk_to_neg,
  output sacb_pkg::sacb_ow_level_t o_src_level,
  output sacb_pkg::sacb_ow_level_t o_snk_level,
  output logic signed [23:0] o_offset_correction
);
  logic [15:0] cfg1_q;
  logic [15:0] cfg2_q;
  logic [15:0] ocalu_q;
  logic standby_s1_q;
  logic standby_s2_q;
  logic pdown_s1_q;
  logic pdown_s2_q;
  logic [23:0] data_q;
  logic [1:0] count_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;
  logic [7:0] idx;
  logic word_ok;
  logic hit_cfg1;
  logic hit_cfg2;
  logic hit_ocalu;
  logic req;
  logic wr_fire;
  logic [15:0] lane_mask;
  logic hold_clear;

  assign idx = i_avs_address[9:2];
  assign word_ok = (i_avs_address[1:0] == 2'h0);
  assign hit_cfg1 = word_ok && (idx == `SACB_IDX_CFG1);
  assign hit_cfg2 = word_ok && (idx == `SACB_IDX_CFG2);
  assign hit_ocalu = word_ok && (idx == `SACB_IDX_OCALU);
  assign req = i_avs_read | i_avs_write;
  // one wait state per access; ack lands on the next edge
  assign o_avs_waitrequest = req & ~ack_q;
  assign wr_fire = i_avs_write & ack_q;
  assign lane_mask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg1_q <= `SACB_RST_CFG1; // [RQ1] [RQ2] [RQ3] [RQ4]
      cfg2_q <= `SACB_RST_CFG2; // [RQ6] [RQ10] [RQ9] [RQ11] [RQ12]
      ocalu_q <= `SACB_RST_OCALU; // [RQ13]
    end else if (wr_fire) begin
      if (hit_cfg1) begin
        cfg1_q <= (cfg1_q & ~lane_mask) | (i_avs_writedata[15:0] & lane_mask & `SACB_MASK_CFG1); // [RQ15]
      end else if (hit_cfg2) begin
        cfg2_q <= (cfg2_q & ~lane_mask) | (i_avs_writedata[15:0] & lane_mask & `SACB_MASK_CFG2); // [RQ15]
      end else if (hit_ocalu) begin
        ocalu_q <= (ocalu_q & ~lane_mask) | (i_avs_writedata[15:0] & lane_mask); // [RQ13]
      end
    end
  end

  // read data and response registered at the acknowledging edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= 32'h0000_0000;
      resp_q <= 2'h0;
    end else if (req & ~ack_q) begin
      resp_q <= (hit_cfg1 | hit_cfg2 | hit_ocalu) ? 2'h0 : 2'h3;
      if (!i_avs_read) begin
        rdata_q <= 32'h0000_0000;
      end else if (hit_cfg1) begin
        rdata_q <= {16'h0000, cfg1_q & `SACB_MASK_CFG1}; // [RQ15]
      end else if (hit_cfg2) begin
        rdata_q <= {16'h0000, cfg2_q & `SACB_MASK_CFG2}; // [RQ15]
      end else if (hit_ocalu) begin
        rdata_q <= {16'h0000, ocalu_q};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end
  assign o_avs_readdata = rdata_q;
  assign o_avs_response = resp_q;

  // pins from the system domain: two flops before use
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      standby_s1_q <= 1'b0;
      standby_s2_q <= 1'b0;
      pdown_s1_q <= 1'b0;
      pdown_s2_q <= 1'b0;
    end else begin
      standby_s1_q <= i_standby;
      standby_s2_q <= standby_s1_q;
      pdown_s1_q <= i_power_down;
      pdown_s2_q <= pdown_s1_q;
    end
  end

  assign hold_clear = ~cfg2_q[`SACB_B_CONV_EN] | standby_s2_q | pdown_s2_q;
  assign o_converter_run = ~hold_clear; // [RQ6]

  // clear wins over a landing result: a disabled converter must not publish
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      data_q <= 24'h00_0000;
      count_q <= 2'h0;
    end else if (hold_clear) begin
      data_q <= 24'h00_0000; // [RQ5]
      count_q <= 2'h0; // [RQ5]
    end else if (i_conv_done) begin
      data_q <= i_conv_data;
      count_q <= count_q + 2'h1;
    end
  end
  assign o_conv_data = data_q;
  assign o_conversion_counter = count_q;

  assign o_conversion_style = sacb_pkg::sacb_conv_style_t'(cfg1_q[`SACB_B_CONV_STYLE]); // [RQ1]
  assign o_global_chop_enable = cfg1_q[`SACB_B_GC_EN]; // [RQ3]
  assign o_src_level = sacb_pkg::sacb_ow_level_t'(cfg2_q[`SACB_B_SRC_LVL_LO +: 2]); // [RQ11]
  assign o_snk_level = sacb_pkg::sacb_ow_level_t'(cfg2_q[`SACB_B_SNK_LVL_LO +: 2]); // [RQ12]
  // lower byte supplied by neighbouring register; value is signed
  assign o_offset_correction = $signed({ocalu_q, i_offset_lower}); // [RQ14] [RQ13]

  sacb_ratio_decode u_ratio (
    .i_osr_code(cfg1_q[`SACB_B_OSR_LO +: 3]),
    .i_delay_code(cfg1_q[`SACB_B_GC_DLY_LO +: 3]),
    .o_osr_ratio(o_osr_ratio),
    .o_chop_delay(o_chop_delay)
  );

  sacb_front_route u_front (
    .i_gain_code(cfg2_q[`SACB_B_GAIN_LO +: 2]),
    .i_mux_code(cfg2_q[`SACB_B_MUX_LO +: 2]),
    .i_src_route(cfg2_q[`SACB_B_SRC_ROUTE]),
    .i_snk_route(cfg2_q[`SACB_B_SNK_ROUTE]),
    .o_analog_gain(o_analog_gain),
    .o_digital_shift(o_digital_shift),
    .o_mux_onehot(o_mux_onehot),
    .o_src_to_pos(o_src_to_pos),
    .o_src_to_neg(o_src_to_neg),
    .o_snk_to_pos(o_snk_to_pos),
    .o_snk_to_neg(o_snk_to_neg)
  );

  a_disable_clears: assert property (@(posedge i_clk) disable iff (i_rst)
    !cfg2_q[`SACB_B_CONV_EN] |=> (o_conv_data == 24'h00_0000) && (o_conversion_counter == 2'h0)) // [RQ5]
    else $error("data not cleared while disabled");
  a_pin_standby_clears: assert property (@(posedge i_clk) disable iff (i_rst)
    i_standby ##1 i_standby ##1 1'b1 |=> o_conversion_counter == 2'h0) // [RQ5]
    else $error("standby did not clear counter");
  a_osr_ratio_map: assert property (@(posedge i_clk) disable iff (i_rst)
    o_osr_ratio == (14'h0040 << cfg1_q[10:8])) // [RQ2]
    else $error("ratio decode wrong");
  a_chop_delay_map: assert property (@(posedge i_clk) disable iff (i_rst)
    (cfg1_q[2:0] == 3'h7) |-> o_chop_delay == 9'h100) // [RQ4]
    else $error("chop delay wrong");
  a_reset_values: assert property (@(posedge i_clk)
    $past(i_rst) |-> cfg1_q == 16'h0400 && cfg2_q == 16'h8010 && ocalu_q == 16'h0000) // [RQ6]
    else $error("reset value wrong");
  a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    (cfg1_q & 16'hf0f0) == 16'h0000 && (cfg2_q & 16'h70c0) == 16'h0000) // [RQ15]
    else $error("reserved bit set");
  a_gain_split: assert property (@(posedge i_clk) disable iff (i_rst)
    cfg2_q[11] |-> o_analog_gain == 4'h8 && o_digital_shift == (cfg2_q[10] ? 3'h2 : 3'h1)) // [RQ7]
    else $error("gain split wrong");
  a_write_lands: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_fire && hit_ocalu && (&i_avs_byteenable[1:0]) |=> ocalu_q == $past(i_avs_writedata[15:0])) // [RQ13]
    else $error("offset write lost");
  a_route_exclusive: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_src_to_neg == cfg2_q[5]) && (o_snk_to_neg == cfg2_q[4]) && $onehot(o_mux_onehot)) // [RQ9] [RQ10] [RQ8]
    else $error("routing wrong");
  a_style_follows: assert property (@(posedge i_clk) disable iff (i_rst)
    o_conversion_style == sacb_pkg::sacb_conv_style_t'(cfg1_q[11]) && o_global_chop_enable == cfg1_q[3]) // [RQ1] [RQ3]
    else $error("style or chop wrong");

  c_write_cfg2: cover property (@(posedge i_clk) wr_fire && hit_cfg2);
  c_disable_run: cover property (@(posedge i_clk) o_converter_run ##1 !o_converter_run);
  c_unmapped_read: cover property (@(posedge i_clk) i_avs_read && ack_q && !word_ok);
  c_conv_count: cover property (@(posedge i_clk) o_conversion_counter == 2'h3);
endmodule : sacb_top

// >>> testbench/tb.sv
`timescale 1ns/1ps
`include "sacb_cfg.svh"
module tb;
  typedef struct {logic [7:0] idx; logic [15:0] wd; logic [31:0] exp;} sacb_row_t;
  logic i_clk, i_rst, rd, wr, conv_done, standby, power_down, waitreq, run, gc, srp, srn, snp, snn;
  logic [9:0] addr;
  logic [31:0] wdata, rdata, got;
  logic [3:0] be, again, onehot;
  logic [7:0] ofs_lo;
  logic [23:0] conv_in, cdata;
  logic [1:0] resp, gresp, cnt;
  logic [13:0] osr;
  logic [8:0] dly;
  logic [2:0] dshift, kc;
  logic signed [23:0] ocorr;
  sacb_pkg::sacb_conv_style_t style;
  sacb_pkg::sacb_ow_level_t srcl, snkl;
  int failures, total_checks;
  // reserved bits written as ones must read back zero; c5h is unmapped
  sacb_row_t rows [5] = '{
    '{`SACB_IDX_CFG1, 16'hffff, 32'h0000_0f0f},
    '{`SACB_IDX_CFG2, 16'h7fff, 32'h0000_0f3f},
    '{`SACB_IDX_OCALU, 16'ha5c3, 32'h0000_a5c3},
    '{8'hc5, 16'h1234, 32'h0000_0000},
    '{`SACB_IDX_CFG2, 16'hffff, 32'h0000_8f3f}};

  sacb_top i_sacb_top (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .o_avs_response(resp), .i_standby(standby), .i_power_down(power_down), .i_offset_lower(ofs_lo),
    .i_conv_done(conv_done), .i_conv_data(conv_in), .o_conv_data(cdata), .o_conversion_counter(cnt),
    .o_converter_run(run), .o_conversion_style(style), .o_osr_ratio(osr), .o_global_chop_enable(gc),
    .o_chop_delay(dly), .o_analog_gain(again), .o_digital_shift(dshift), .o_mux_onehot(onehot),
    .o_src_to_pos(srp), .o_src_to_neg(srn), .o_snk_to_pos(snp), .o_snk_to_neg(snn), .o_src_level(srcl),
    .o_snk_level(snkl), .o_offset_correction(ocorr));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  // request held until the rising edge that sees waitrequest low; answer taken there
  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge i_clk);
    addr <= {idx, 2'b00};
    rd <= !w;
    wr <= w;
    wdata <= {16'h0000, d};
    be <= b;
    do begin
      @(posedge i_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (waitreq !== 1'b0) begin
      failures++;
      end_sim;
    end
    got = rdata;
    gresp = resp;
    rd <= 1'b0;
    wr <= 1'b0;
    @(negedge i_clk);
  endtask : bus

  task automatic pulse(input logic [23:0] d);
    @(posedge i_clk);
    conv_done <= 1'b1;
    conv_in <= d;
    @(posedge i_clk);
    conv_done <= 1'b0;
    @(negedge i_clk);
  endtask : pulse

  initial begin
    {rd, wr, conv_done, standby, power_down} = 5'h00;
    addr = 10'h000;
    wdata = 32'h0000_0000;
    be = 4'hf;
    ofs_lo = 8'h00;
    conv_in = 24'h00_0000;
    i_rst = 1'b1;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    bus(0, `SACB_IDX_CFG1, 16'h0000, 4'hf);
    chk(got, 32'h0000_0400, "cfg1 reset");
    bus(0, `SACB_IDX_CFG2, 16'h0000, 4'hf);
    chk(got, 32'h0000_8010, "cfg2 reset");
    bus(0, `SACB_IDX_OCALU, 16'h0000, 4'hf);
    chk(got, 32'h0000_0000, "ocal reset");
    chk({style, gc, osr, dly}, {1'b0, 1'b0, 14'h0400, 9'h002}, "cfg1 decode reset");
    chk({run, srp, srn, snp, snn, srcl, snkl}, {5'h19, 4'h0}, "cfg2 decode reset");
    foreach (rows[i]) begin
      bus(1, rows[i].idx, rows[i].wd, 4'hf);
      bus(0, rows[i].idx, 16'h0000, 4'hf);
      chk(got, rows[i].exp, "readback");
      chk(gresp, (rows[i].idx == 8'hc5) ? 2'b11 : 2'b00, "response");
    end
    for (int k = 0; k < 8; k++) begin
      kc = k[2:0];
      bus(1, `SACB_IDX_CFG1, {4'h0, kc[0], kc, 4'h0, kc[1], kc}, 4'hf);
      chk(osr, `SACB_OSR_BASE << kc, "ratio");
      chk(dly, `SACB_GC_DLY_BASE << kc, "chop delay");
      chk({style, gc}, {kc[0], kc[1]}, "style and chop");
    end
    for (int k = 0; k < 4; k++) begin
      kc = k[2:0];
      bus(1, `SACB_IDX_CFG2, {4'h8, kc[1:0], kc[1:0], 2'h0, kc[0], kc[1], kc[1:0], kc[1:0]}, 4'hf);
      chk(again, kc[1] ? 32'h8 : (32'h4 << kc[1:0]), "analog gain");
      chk(dshift, kc[1] ? kc[1:0] - 2'h1 : 2'h0, "digital shift");
      chk(onehot, 32'h1 << kc[1:0], "mux");
      chk({srp, srn, snp, snn}, {!kc[0], kc[0], !kc[1], kc[1]}, "routing");
      chk({srcl, snkl}, {kc[1:0], kc[1:0]}, "levels");
    end
    // only lane 0 enabled: upper byte must keep its value
    bus(1, `SACB_IDX_CFG2, 16'h0000, 4'h1);
    bus(0, `SACB_IDX_CFG2, 16'h0000, 4'hf);
    chk(got, 32'h0000_8f00, "byte lane");
    ofs_lo <= 8'h45;
    bus(1, `SACB_IDX_OCALU, 16'h8123, 4'hf);
    chk(ocorr, 32'hff81_2345, "offset word");
    repeat (5) pulse(24'hab_cdef);
    chk({cdata, cnt}, {24'hab_cdef, 2'h1}, "result and count");
    bus(1, `SACB_IDX_CFG2, 16'h0010, 4'hf);
    @(negedge i_clk);
    chk({cdata, cnt, run}, 32'h0, "disable clears");
    pulse(24'h12_3456);
    chk({cdata, cnt}, 32'h0, "disabled result dropped");
    bus(1, `SACB_IDX_CFG2, 16'h8010, 4'hf);
    for (int m = 0; m < 2; m++) begin
      pulse(24'h65_4321);
      chk({cdata, cnt}, {24'h65_4321, 2'h1}, "result before low power");
      standby <= (m == 0);
      power_down <= (m == 1);
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
      chk({cdata, cnt, run}, 32'h0, "low power clears");
      standby <= 1'b0;
      power_down <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
    @(posedge i_clk);
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    bus(0, `SACB_IDX_CFG2, 16'h0000, 4'hf);
    chk(got, 32'h0000_8010, "second reset");
    end_sim;
  end
endmodule : tb
